// ---- hdl/dual_edge_capture_measure.sv ----
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Contract
// (RULE1) Enhanced, dual-capture, mode-A set: continuous mode
// (RULE2) Continuous: repeat pairs; even initial, odd final
// (RULE3) Software clears flags, then arms capture
// (RULE4) Odd flag set: registers hold newest pair
// (RULE5) Odd-only clear; re-set on next pair
// (RULE6) New series: software clears both flags
// (RULE7) Rise then fall: positive pulse width
// (RULE8) Fall then rise: negative pulse width
// (RULE9) Both rising: rising edge period
// (RULE10) Both falling: falling edge period
// (RULE11) One-shot: even first, odd second, disarm
// (RULE12) Continuous armed: even each first, odd second
// (RULE13) Software keeps dual-capture enable set
// (RULE14) Only even input sampled; odd ignored
// (RULE15) Odd flag needs even flag; interrupts enabled
// (RULE16) Even edge buffers count; moves at odd
// (RULE17) Odd buffer moves on even register read
// (RULE18) Flag clears never disturb running captures
module dual_edge_capture_measure #(
    parameter int CNT_W = 16,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Timer counter and measured input
    input wire logic [CNT_W-1:0] timer_count,
    input wire logic even_in,
    // Interrupt
    output logic irq
);
    import dual_capture_pkg::*;

    // Register state
    ctrl_t ctrl, next_ctrl;
    pair_t flags, next_flags;
    pair_t mask, next_mask;
    logic [CNT_W-1:0] even_buf, next_even_buf;     // Latest initial-edge capture
    logic [CNT_W-1:0] odd_buf, next_odd_buf;       // Latest final-edge capture
    logic [CNT_W-1:0] even_value, next_even_value; // Readable even register
    logic [CNT_W-1:0] odd_value, next_odd_value;   // Readable odd register
    logic in_prev;                                 // Previous input sample
    logic [31:0] next_rd_data;
    logic next_irq;

    // Decoded strobes and events
    logic wr_ctrl, wr_status, wr_mask, rd_even;
    logic rise, fall, active, even_hit, odd_hit;

    // Address decode; only the low byte of the address carries offsets
    // Upper address bits are not decoded, so the map repeats above 0xff
    assign wr_ctrl = wr_en && (addr[7:0] == CTRL_OFFSET);
    assign wr_status = wr_en && (addr[7:0] == STATUS_OFFSET);
    assign wr_mask = wr_en && (addr[7:0] == MASK_OFFSET);
    assign rd_even = rd_en && (addr[7:0] == EVEN_VALUE_OFFSET);

    // Edge detection on the even input only; no odd input exists
    // The pin is taken as synchronous; an async source must be staged upstream
    // (RULE14) even input only
    assign rise = even_in && !in_prev;
    assign fall = !even_in && in_prev;

    // Captures run only with the mode enabled and armed
    // Arm alone is not enough: software may leave it set while dropping the mode
    // (RULE1) mode enable gate
    assign active = ctrl.enhanced_features_enable && ctrl.dual_capture_enable
        && ctrl.capture_arm;

    // Selected edges; codes 00 and 11 match nothing
    // Period mode: one edge is both the final edge and the next initial edge
    // (RULE7) polarity by edge codes
    // (RULE8) polarity by edge codes
    // (RULE9) same edge gives period
    // (RULE10) same edge gives period
    assign even_hit = active && ((ctrl.even_edge_select == SEL_RISE && rise)
        || (ctrl.even_edge_select == SEL_FALL && fall));
    // (RULE15) odd waits for even flag
    assign odd_hit = active && flags.even
        && ((ctrl.odd_edge_select == SEL_RISE && rise)
        || (ctrl.odd_edge_select == SEL_FALL && fall));

    // Next-state logic for control, flags and capture storage
    always_comb begin
        next_ctrl = ctrl;
        next_mask = mask;
        next_flags = flags;
        next_even_buf = even_buf;
        next_odd_buf = odd_buf;
        next_even_value = even_value;
        next_odd_value = odd_value;
        // Control write first, so the one-shot disarm further down beats it
        if (wr_ctrl) begin
            next_ctrl = ctrl_t'(wr_data[7:0]);
        end
        // Mask write; the interrupt follows it from the next cycle on
        if (wr_mask) begin
            next_mask = pair_t'(wr_data[1:0]);
        end
        // Write one to clear; capture sets below win over it
        // (RULE18) clear leaves captures alone
        if (wr_status) begin
            next_flags = pair_t'(flags & ~wr_data[1:0]);
        end
        // (RULE16) buffer on initial edge
        if (even_hit) begin
            next_even_buf = timer_count;
            next_flags.even = 1'b1;
        end
        // (RULE12) odd set per pair
        if (odd_hit) begin
            // (RULE16) buffer moves at final edge
            next_even_value = even_buf;
            next_odd_buf = timer_count;
            // (RULE5) odd flag set again
            next_flags.odd = 1'b1;
            // (RULE11) one-shot disarms itself
            if (!ctrl.even_mode_select_a) begin
                next_ctrl.capture_arm = 1'b0;
            end
            // (RULE2) continuous stays armed
        end
        // Reading the even register releases the matching odd value
        // (RULE17) coherent read transfer
        if (rd_even) begin
            next_odd_value = odd_buf;
        end
    end

    // Read data mux and interrupt; unmapped reads return zero
    // Registered read data costs a cycle but keeps the output glitch free
    always_comb begin
        next_rd_data = 32'h0;
        if (rd_en) begin
            case (addr[7:0])
                CTRL_OFFSET: next_rd_data = {24'h0, ctrl};
                STATUS_OFFSET: next_rd_data = {30'h0, flags};
                MASK_OFFSET: next_rd_data = {30'h0, mask};
                // (RULE4) values stay readable
                EVEN_VALUE_OFFSET: next_rd_data = 32'(even_value);
                ODD_VALUE_OFFSET: next_rd_data = 32'(odd_value);
                COUNT_OFFSET: next_rd_data = 32'(timer_count);
                default: next_rd_data = 32'h0;
            endcase
        end
        // Built from next values so the interrupt tracks the flags cycle for cycle
        // (RULE15) flag raises enabled interrupt
        next_irq = |(next_flags & next_mask);
    end

    // State registers
    // Synchronous reset; every output comes straight from a flop
    // Values are cleared so no stale capture reads back after reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl <= ctrl_t'(CTRL_RESET);
            flags <= pair_t'(FLAGS_RESET);
            mask <= pair_t'(MASK_RESET);
            even_buf <= '0;
            odd_buf <= '0;
            even_value <= '0;
            odd_value <= '0;
            in_prev <= 1'b0;
            rd_data <= 32'h0;
            irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            flags <= next_flags;
            mask <= next_mask;
            even_buf <= next_even_buf;
            odd_buf <= next_odd_buf;
            even_value <= next_even_value;
            odd_value <= next_odd_value;
            in_prev <= even_in;
            rd_data <= next_rd_data;
            irq <= next_irq;
        end
    end

    // Checks on the capture behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Flags only rise from armed captures
    // (RULE12) even needs arm
    a_even_needs_arm: assert property ($rose(flags.even) |-> $past(active)) // (RULE12)
        else $error("even flag rose while not armed");
    // (RULE15) odd needs even
    a_odd_after_even: assert property ($rose(flags.odd) |-> $past(flags.even)) // (RULE15)
        else $error("odd flag rose without even flag");
    // (RULE12) even flag per hit
    a_even_flag_set: assert property (even_hit |=> flags.even) // (RULE12)
        else $error("even flag not set on initial edge");
    // (RULE12) odd flag per hit
    a_odd_flag_set: assert property (odd_hit |=> flags.odd) // (RULE12)
        else $error("odd flag not set on final edge");
    // (RULE1) disarmed keeps quiet
    a_disarmed_quiet: assert property (
        !active && !wr_status |=> $stable(flags)) // (RULE1)
        else $error("flags moved while not armed");

    // One-shot and continuous arm handling
    // (RULE11) one-shot disarm
    a_oneshot_disarm: assert property (
        odd_hit && !ctrl.even_mode_select_a |=> !ctrl.capture_arm && flags.odd) // (RULE11)
        else $error("one-shot did not disarm");
    // (RULE11) disarm stays off
    a_oneshot_stays_off: assert property (
        !ctrl.capture_arm && !wr_ctrl |=> !ctrl.capture_arm) // (RULE11)
        else $error("arm set without a control write");
    // (RULE2) continuous stays armed
    a_continuous_rearm: assert property (
        odd_hit && ctrl.even_mode_select_a && !wr_ctrl |=> ctrl.capture_arm) // (RULE2)
        else $error("continuous mode lost arm");

    // Capture storage
    // (RULE16) even buffer load
    a_even_buffer: assert property (even_hit |=> even_buf == $past(timer_count)) // (RULE16)
        else $error("even buffer missed counter");
    // (RULE16) even buffer holds
    a_even_buf_hold: assert property (!even_hit |=> $stable(even_buf)) // (RULE16)
        else $error("even buffer changed without edge");
    // (RULE16) odd buffer holds
    a_odd_buf_hold: assert property (!odd_hit |=> $stable(odd_buf)) // (RULE16)
        else $error("odd buffer changed without edge");
    // (RULE4) pair transfer
    a_pair_transfer: assert property (
        odd_hit |=> even_value == $past(even_buf) && odd_buf == $past(timer_count)) // (RULE4)
        else $error("edge pair not transferred");
    // (RULE17) release on read
    a_coherent_read: assert property (rd_even |=> odd_value == $past(odd_buf)) // (RULE17)
        else $error("odd value not released on even read");
    // (RULE17) odd value holds
    a_odd_value_hold: assert property (!rd_even |=> $stable(odd_value)) // (RULE17)
        else $error("odd value changed without even read");
    // (RULE4) value stays put
    a_value_hold: assert property (!odd_hit |=> $stable(even_value)) // (RULE4)
        else $error("even value changed without pair");

    // Read port
    // (RULE4) idle read data
    a_rd_idle: assert property (!rd_en |=> rd_data == 32'h0) // (RULE4)
        else $error("read data not zero after idle cycle");
    // (RULE4) even value readable
    a_rd_even_data: assert property (
        rd_even |=> rd_data == 32'($past(even_value))) // (RULE4)
        else $error("even value read back wrong");
    // (RULE17) odd value readable
    a_rd_odd_data: assert property (
        rd_en && addr[7:0] == ODD_VALUE_OFFSET |=> rd_data == 32'($past(odd_value))) // (RULE17)
        else $error("odd value read back wrong");

    // Edge selection
    // (RULE7) rising initial edge
    a_pos_pulse: assert property (
        active && ctrl.even_edge_select == SEL_RISE && rise |=> flags.even) // (RULE7)
        else $error("rising initial edge missed");
    // (RULE8) falling initial edge
    a_neg_pulse: assert property (
        active && ctrl.even_edge_select == SEL_FALL && fall |=> flags.even) // (RULE8)
        else $error("falling initial edge missed");
    // (RULE10) falling final edge
    a_fall_period: assert property (
        odd_hit && ctrl.odd_edge_select == SEL_FALL |-> fall) // (RULE10)
        else $error("odd capture on wrong edge");
    // (RULE9) rising final edge
    a_rise_period: assert property (
        odd_hit && ctrl.odd_edge_select == SEL_RISE |-> rise) // (RULE9)
        else $error("odd capture on wrong rising edge");

    // Interrupt and flag clears
    // (RULE15) interrupt follows flags
    a_irq_level: assert property ((flags & mask) != 2'h0 |-> irq) // (RULE15)
        else $error("interrupt missing");
    // (RULE15) no stray interrupt
    a_irq_clear: assert property (
        (flags & mask) == 2'h0 |-> !irq) // (RULE15)
        else $error("interrupt without enabled flag");
    // (RULE18) set beats clear
    a_clear_set_win: assert property (wr_status && odd_hit |=> flags.odd) // (RULE18)
        else $error("set lost to clear");
    // (RULE5) odd-only clear
    a_clear_odd_only: assert property (
        wr_status && wr_data[1:0] == 2'h2 && !odd_hit && !even_hit
        |=> !flags.odd && flags.even == $past(flags.even)) // (RULE5)
        else $error("odd-only clear disturbed flags");

    // Main scenarios
    c_cont_pulse: cover property (ctrl.even_mode_select_a && odd_hit
        && ctrl.even_edge_select == SEL_RISE && ctrl.odd_edge_select == SEL_FALL);
    c_oneshot_period: cover property (!ctrl.even_mode_select_a && odd_hit
        && ctrl.even_edge_select == ctrl.odd_edge_select);
    c_odd_reflag: cover property (wr_status && wr_data[1:0] == 2'h2 ##[1:200] odd_hit);
    c_cont_neg_pulse: cover property (ctrl.even_mode_select_a && odd_hit
        && ctrl.even_edge_select == SEL_FALL && ctrl.odd_edge_select == SEL_RISE);
    c_cont_fall_period: cover property (ctrl.even_mode_select_a && odd_hit
        && ctrl.even_edge_select == SEL_FALL && ctrl.odd_edge_select == SEL_FALL);
endmodule // dual_edge_capture_measure

// ---- hdl/dual_capture_pkg.sv ----
package dual_capture_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] EVEN_VALUE_OFFSET = 8'h0c;
    localparam logic [7:0] ODD_VALUE_OFFSET = 8'h10;
    localparam logic [7:0] COUNT_OFFSET = 8'h14;
    // Control field positions
    localparam int ENH_POS = 0;
    localparam int DCE_POS = 1;
    localparam int ARM_POS = 2;
    localparam int MODE_POS = 3;
    localparam int EVEN_SEL_POS = 4;
    localparam int ODD_SEL_POS = 6;
    // Status and mask field positions
    localparam int EVEN_FLAG_POS = 0;
    localparam int ODD_FLAG_POS = 1;
    // Edge select codes
    localparam logic [1:0] SEL_RISE = 2'h1;
    localparam logic [1:0] SEL_FALL = 2'h2;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // Control register layout, msb first
    typedef struct packed {
        logic [1:0] odd_edge_select;
        logic [1:0] even_edge_select;
        logic even_mode_select_a;
        logic capture_arm;
        logic dual_capture_enable;
        logic enhanced_features_enable;
    } ctrl_t;

    // Channel pair flags or enables
    typedef struct packed {
        logic odd;
        logic even;
    } pair_t;
endpackage

// ---- testbench/signal_source.sv ----
`timescale 1ns/1ps
// Measured pin and free-running counter seen by the capture pair
module signal_source (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Counter and pin
    output logic [15:0] timer_count,
    output logic even_in = 1'b0
);
    // Counter runs free outside reset
    always @(posedge ref_clk) begin
        timer_count <= reset ? 16'h0 : timer_count + 16'h1;
    end

    task automatic set_level(input logic v);
        @(posedge ref_clk);
        even_in <= v;
    endtask

    // Gap keeps pulses wide; returns the count the edge should latch
    task automatic tog(output logic [15:0] t);
        repeat (4) @(posedge ref_clk);
        even_in <= ~even_in;
        #1 t = timer_count;
    endtask
endmodule // signal_source

// ---- testbench/test_dual_edge_capture_measure.sv ----
`timescale 1ns/1ps
module test_dual_edge_capture_measure;
    import dual_capture_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    logic [15:0] timer_count;
    logic even_in;
    logic irq;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    initial forever #12.5 ref_clk = ~ref_clk;

    dual_edge_capture_measure uut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .timer_count(timer_count), .even_in(even_in), .irq(irq));
    signal_source src (.ref_clk(ref_clk), .reset(reset), .timer_count(timer_count),
        .even_in(even_in));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // Reset values, with an unmapped place in place of the live count
    task automatic test_reset;
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            rd((i == 5) ? 8'h20 : 8'(i * 4), d);
            chk(d, 32'h0);
        end
        // Live count is the one seen at the strobe edge, one behind now
        rd(COUNT_OFFSET, d);
        chk(d, {16'h0, timer_count - 16'h1});
        @(posedge ref_clk);
        #1 chk(rd_data, 32'h0);
        $display("reset values done");
    endtask

    // One-shot positive pulse, starting high so a stray fall comes first
    task automatic test_one_shot;
        logic [31:0] d;
        logic [15:0] t0, t1, tx;
        src.set_level(1'b1);
        wr(MASK_OFFSET, 32'h0);
        wr(STATUS_OFFSET, 32'h3);
        wr(CTRL_OFFSET, 32'h97);
        src.tog(tx);
        rd(STATUS_OFFSET, d);
        chk(d, 32'h0);
        src.tog(t0);
        rd(STATUS_OFFSET, d);
        chk(d, 32'h1);
        src.tog(t1);
        rd(CTRL_OFFSET, d);
        chk(d, 32'h93);
        src.tog(tx);
        src.tog(tx);
        chk({31'h0, irq}, 32'h0);
        wr(MASK_OFFSET, 32'h2);
        rd(EVEN_VALUE_OFFSET, d);
        chk(d, {16'h0, t0});
        chk({31'h0, irq}, 32'h1);
        rd(ODD_VALUE_OFFSET, d);
        chk(d, {16'h0, t1});
        wr(STATUS_OFFSET, 32'h2);
        rd(STATUS_OFFSET, d);
        chk(d, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("one-shot done");
    endtask

    // Continuous capture of two pairs for one edge-select combination
    task automatic test_cont(input logic [1:0] es, input logic [1:0] os);
        logic [31:0] d;
        logic [15:0] ev, t;
        src.set_level(es == SEL_FALL);
        wr(STATUS_OFFSET, 32'h3);
        wr(CTRL_OFFSET, {24'h0, os, es, 4'hf});
        src.tog(ev);
        for (int k = 0; k < 2; k++) begin
            if (es == os) src.tog(t);
            src.tog(t);
            rd(STATUS_OFFSET, d);
            chk(d, 32'h3);
            rd(EVEN_VALUE_OFFSET, d);
            chk(d, {16'h0, ev});
            rd(ODD_VALUE_OFFSET, d);
            chk(d, {16'h0, t});
            wr(STATUS_OFFSET, 32'h2);
            rd(STATUS_OFFSET, d);
            chk(d, 32'h1);
            if (es == os) ev = t;
            else src.tog(ev);
        end
        wr(CTRL_OFFSET, 32'h0);
        $display("continuous %0d %0d done", es, os);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        test_reset();
        test_one_shot();
        test_cont(SEL_RISE, SEL_FALL);
        test_cont(SEL_FALL, SEL_RISE);
        test_cont(SEL_RISE, SEL_RISE);
        test_cont(SEL_FALL, SEL_FALL);
        wrap_up();
    end
endmodule // test_dual_edge_capture_measure
